/* File: rtl/hor_host_oob_init.sv */
`timescale 1ns/1ps
`include "hor_defines.svh"

// Overview of operation
// - Power-on reset or explicit reset request sends the host to reset.
// - That reset entry happens from any state, at any moment.
// - With async recovery, COMINIT in the calibrate state forces reset.
// - Reset sends at least six bursts, total a multiple of six.
// - Bursts may run during the whole reset stay or start on leaving.
// - After async COMINIT entry, bursts finish within 10 ms of its end.
// - Without COMINIT, stay waiting unless recovery on and retry expired.
// - With recovery on, retry expiry without COMINIT returns to reset.
// - Leave reset for wait-for-init once both reset sources are negated, a burst group was sent and none is running.
// - Stay in wait-clear while COMINIT is seen; then go to calibrate.
module hor_host_oob_init #(
   parameter int RETRY_CYC = `HOR_RETRY_CYC, // retry interval in cycles
   parameter int FINISH_CYC = `HOR_FINISH_CYC // burst finish bound
) (
   input wire logic core_clk, // 40 MHz clock
   input wire logic srst, // power-on reset, synchronous, active high
   input wire logic reset_req, // explicit reset request, active high
   input wire logic async_rec_en, // async signal recovery supported
   input wire logic cominit_pin, // COMINIT detector output, asynchronous
   output logic tx_comreset, // drive a COMRESET burst now
   output logic in_reset, // host is in host_reset_state
   output logic in_wait_init, // host is in wait_device_init_state
   output logic in_wait_clear, // host is in wait_init_clear_state
   output logic calib_go // handed off to host_calibrate_state
);

   hor_pkg::hor_top_s r;
   hor_pkg::hor_top_s next_r;
   logic gen_run;
   logic gen_busy;
   logic gen_end;
   logic retry_done;

   // Bursts run for the whole reset stay, but a new group starts only while
   // the request stands or before any group went out. Otherwise the
   // generator would never go idle and the host could not leave reset.
   assign gen_run = (r.st == hor_pkg::host_reset_state) &&
      (reset_req || (!gen_busy && !r.sent && !gen_end));

   hor_burst_gen u_gen (
      .core_clk(core_clk),
      .srst(srst),
      .run(gen_run),
      .tx_burst(tx_comreset),
      .busy(gen_busy),
      .group_end(gen_end)
   );

   assign retry_done = async_rec_en &&
      (r.retry == `HOR_RETRY_W'(RETRY_CYC - 1));

   always_comb begin
      next_r = r;
      // The first flop only feeds the second; the level counts once the
      // second and third agree, which filters a single metastable sample.
      next_r.sync = {r.sync[`HOR_SYNC_W-2:0], cominit_pin};
      if (r.sync[`HOR_SYNC_W-1] == r.sync[`HOR_SYNC_W-2]) begin
         next_r.cominit = r.sync[`HOR_SYNC_W-1];
      end
      unique case (r.st)
         hor_pkg::host_reset_state: begin
            next_r.retry = '0;
            if (gen_end) begin
               next_r.sent = 1'b1;
            end
            if (!reset_req && !gen_busy && r.sent) begin
               next_r.st = hor_pkg::wait_device_init_state;
               next_r.sent = 1'b0;
            end
         end
         hor_pkg::wait_device_init_state: begin
            if (r.cominit) begin
               next_r.st = hor_pkg::wait_init_clear_state;
            end else if (retry_done) begin
               next_r.st = hor_pkg::host_reset_state;
            end else begin
               next_r.retry = r.retry + `HOR_RETRY_W'(1);
            end
         end
         hor_pkg::wait_init_clear_state: begin
            if (!r.cominit) begin
               next_r.st = hor_pkg::host_calibrate_state;
            end
         end
         hor_pkg::host_calibrate_state: begin
            next_r.st = r.st;
         end
      endcase
      if (async_rec_en && r.cominit &&
          r.st == hor_pkg::host_calibrate_state) begin
         next_r.st = hor_pkg::host_reset_state;
      end
      // The request beats every other exit, whatever the state.
      if (reset_req) begin
         next_r.st = hor_pkg::host_reset_state;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         r <= '0;
         r.st <= hor_pkg::host_reset_state;
      end else begin
         r <= next_r;
      end
   end

   assign in_reset = (r.st == hor_pkg::host_reset_state);
   assign in_wait_init = (r.st == hor_pkg::wait_device_init_state);
   assign in_wait_clear = (r.st == hor_pkg::wait_init_clear_state);
   assign calib_go = (r.st == hor_pkg::host_calibrate_state);

   // Helper state read only by the assertions below.
   logic [7:0] chk_bursts;
   logic [`HOR_RETRY_W+2:0] chk_fin;
   logic chk_tx_q;

   always_ff @(posedge core_clk) begin
      if (srst || !in_reset) begin
         chk_bursts <= '0;
         chk_fin <= '0;
      end else begin
         if (tx_comreset && !chk_tx_q) begin
            chk_bursts <= chk_bursts + 8'h01;
         end
         if (gen_busy && !r.cominit) begin
            chk_fin <= chk_fin + (`HOR_RETRY_W+3)'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         chk_tx_q <= 1'b0;
      end else begin
         chk_tx_q <= tx_comreset;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   property p_req_reset;
      reset_req |=> in_reset;
   endproperty
   a_req_reset: assert property (p_req_reset)
      else $error("reset request did not enter reset");

   property p_req_any_state;
      $rose(reset_req) && !in_reset |=> in_reset ##1 (in_reset || !reset_req);
   endproperty
   a_req_any_state: assert property (p_req_any_state)
      else $error("reset entry not immediate from running state");

   property p_async_cominit;
      async_rec_en && r.cominit && calib_go |=> in_reset;
   endproperty
   a_async_cominit: assert property (p_async_cominit)
      else $error("COMINIT in calibrate did not force reset");

   property p_burst_groups;
      $fell(in_reset) |-> chk_bursts >= 8'(`HOR_BURSTS_PER_GRP) &&
         (chk_bursts % 8'(`HOR_BURSTS_PER_GRP)) == 8'h00;
   endproperty
   a_burst_groups: assert property (p_burst_groups)
      else $error("burst count not a non-zero multiple of six");

   property p_tx_only_reset;
      !in_reset && !$past(in_reset) |-> !tx_comreset;
   endproperty
   a_tx_only_reset: assert property (p_tx_only_reset)
      else $error("burst sent outside reset stay");

   property p_finish;
      in_reset |-> chk_fin < (`HOR_RETRY_W+3)'(FINISH_CYC);
   endproperty
   a_finish: assert property (p_finish)
      else $error("bursts not finished within bound");

   property p_wait_quiet;
      in_wait_init |-> !tx_comreset ##1 (!in_wait_init || !tx_comreset);
   endproperty
   a_wait_quiet: assert property (p_wait_quiet)
      else $error("transmitter active while waiting for init");

   property p_wait_advance;
      in_wait_init && r.cominit && !reset_req |=> in_wait_clear;
   endproperty
   a_wait_advance: assert property (p_wait_advance)
      else $error("COMINIT did not advance wait state");

   property p_wait_hold;
      in_wait_init && !r.cominit && !retry_done && !reset_req
         |=> in_wait_init;
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("left wait state without cause");

   property p_retry;
      in_wait_init && !r.cominit && retry_done && !reset_req |=> in_reset;
   endproperty
   a_retry: assert property (p_retry)
      else $error("retry expiry did not return to reset");

   property p_leave_reset;
      in_reset && !reset_req && !gen_busy && r.sent |=> in_wait_init;
   endproperty
   a_leave_reset: assert property (p_leave_reset)
      else $error("reset not left after both sources negated");

   property p_clear;
      in_wait_clear && !reset_req |=>
         $past(r.cominit) ? in_wait_clear : calib_go;
   endproperty
   a_clear: assert property (p_clear)
      else $error("wait-clear exit on wrong COMINIT level");

   c_handoff: cover property (in_wait_clear ##1 calib_go);
   c_retry: cover property (in_wait_init ##1 in_reset);
   c_async: cover property (calib_go && r.cominit ##1 in_reset);

endmodule

/* File: rtl/hor_defines.svh */
`ifndef HOR_DEFINES_SVH
`define HOR_DEFINES_SVH

// Clock rate of core_clk in MHz (25 ns period).
`define HOR_CLK_MHZ 40

// One out-of-band burst and the quiet gap that follows it.
`define HOR_BURST_NS 107
`define HOR_GAP_NS 320
`define HOR_BURST_CYC ((`HOR_BURST_NS * `HOR_CLK_MHZ + 999) / 1000)
`define HOR_GAP_CYC ((`HOR_GAP_NS * `HOR_CLK_MHZ) / 1000)

// Bursts are always sent in whole groups of this size.
`define HOR_BURSTS_PER_GRP 6
`define HOR_GEN_CNT_W 4
`define HOR_GEN_IDX_W 3

// Retry interval in the wait-for-device-init state.
`define HOR_RETRY_US 10000
`define HOR_RETRY_CYC (`HOR_RETRY_US * `HOR_CLK_MHZ)
`define HOR_RETRY_W 20

// Bound on finishing the reset bursts after an async entry.
`define HOR_FINISH_MS 10
`define HOR_FINISH_CYC (`HOR_FINISH_MS * 1000 * `HOR_CLK_MHZ)

// Input synchroniser depth for the detector pin.
`define HOR_SYNC_W 3

`endif

/* File: rtl/hor_pkg.sv */
`include "hor_defines.svh"

package hor_pkg;

   typedef enum logic [1:0] {
      host_reset_state,
      wait_device_init_state,
      wait_init_clear_state,
      host_calibrate_state
   } hor_state_e;

   typedef struct packed {
      hor_state_e st;
      logic [`HOR_SYNC_W-1:0] sync;
      logic cominit;
      logic [`HOR_RETRY_W-1:0] retry;
      logic sent;
   } hor_top_s;

   typedef struct packed {
      logic active;
      logic on;
      logic [`HOR_GEN_IDX_W-1:0] idx;
      logic [`HOR_GEN_CNT_W-1:0] cnt;
      logic group_end;
   } hor_gen_s;

endpackage

/* File: rtl/hor_burst_gen.sv */
`timescale 1ns/1ps
`include "hor_defines.svh"

// Sends the reset burst pattern in whole groups while run is high. A group
// that has started always completes, so the total is a multiple of a group.
module hor_burst_gen (
   input wire logic core_clk, // 40 MHz clock
   input wire logic srst, // synchronous reset, active high
   input wire logic run, // keep sending groups
   output logic tx_burst, // burst being driven on the line
   output logic busy, // a group is in progress
   output logic group_end // one-cycle pulse after a full group
);

   hor_pkg::hor_gen_s r;
   hor_pkg::hor_gen_s next_r;

   always_comb begin
      next_r = r;
      next_r.group_end = 1'b0;
      if (!r.active) begin
         if (run) begin
            next_r.active = 1'b1;
            next_r.on = 1'b1;
            next_r.idx = '0;
            next_r.cnt = '0;
         end
      end else if (r.on) begin
         if (r.cnt == `HOR_GEN_CNT_W'(`HOR_BURST_CYC - 1)) begin
            next_r.on = 1'b0;
            next_r.cnt = '0;
         end else begin
            next_r.cnt = r.cnt + `HOR_GEN_CNT_W'(1);
         end
      end else if (r.cnt == `HOR_GEN_CNT_W'(`HOR_GAP_CYC - 1)) begin
         next_r.cnt = '0;
         if (r.idx == `HOR_GEN_IDX_W'(`HOR_BURSTS_PER_GRP - 1)) begin
            next_r.group_end = 1'b1;
            next_r.idx = '0;
            next_r.on = run;
            next_r.active = run;
         end else begin
            next_r.idx = r.idx + `HOR_GEN_IDX_W'(1);
            next_r.on = 1'b1;
         end
      end else begin
         next_r.cnt = r.cnt + `HOR_GEN_CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign tx_burst = r.on;
   assign busy = r.active;
   assign group_end = r.group_end;

endmodule

/* File: dv/hor_dev_model.sv */
`timescale 1ns/1ps

// Device end of the link. It answers a finished COMRESET group with COMINIT.
module hor_dev_model (
   input wire logic core_clk, // 40 MHz clock
   input wire logic tx_comreset, // burst from the host
   input wire logic answer_en, // answer at all
   input wire logic [7:0] resp_dly, // quiet cycles before answering
   output logic cominit // COMINIT detector level seen by the host
);
   logic seen = 1'b0;
   logic [7:0] quiet = 8'h00;
   logic [7:0] hold = 8'h00;
   initial cominit = 1'b0;
   // Waiting for a quiet spell longer than a gap avoids answering mid-group.
   always @(posedge core_clk) begin
      if (tx_comreset) begin
         seen <= 1'b1;
         quiet <= 8'h00;
      end else if (quiet != 8'hFF) begin
         quiet <= quiet + 8'h01;
      end
      if (seen && answer_en && !tx_comreset && quiet == resp_dly) begin
         seen <= 1'b0;
         hold <= 8'h28;
      end else if (hold != 8'h00) begin
         hold <= hold - 8'h01;
      end
      cominit <= (hold != 8'h00);
   end
endmodule

/* File: dv/host_oob_reset_init_tb_top.sv */
`timescale 1ns/1ps

module host_oob_reset_init_tb_top;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic reset_req = 1'b0;
   logic async_rec_en = 1'b1;
   logic answer_en = 1'b1;
   logic [7:0] resp_dly = 8'h14;
   logic tb_cin = 1'b0;
   logic dev_cin, tx_comreset, in_reset, in_wait_init, in_wait_clear, calib_go;
   logic cominit_pin, tx_prev;
   int err_count = 0;
   int checks_done = 0;
   int bursts = 0;
   int noisy = 0;

   assign cominit_pin = dev_cin | tb_cin;

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   hor_host_oob_init #(.RETRY_CYC(200), .FINISH_CYC(1000)) uut (
      .core_clk(core_clk), .srst(srst), .reset_req(reset_req),
      .async_rec_en(async_rec_en), .cominit_pin(cominit_pin),
      .tx_comreset(tx_comreset), .in_reset(in_reset),
      .in_wait_init(in_wait_init), .in_wait_clear(in_wait_clear),
      .calib_go(calib_go));

   hor_dev_model dev (.core_clk(core_clk), .tx_comreset(tx_comreset),
      .answer_en(answer_en), .resp_dly(resp_dly), .cominit(dev_cin));

   // Count burst starts, and any burst seen while waiting for the device.
   always @(posedge core_clk) begin
      tx_prev <= tx_comreset;
      if (tx_comreset === 1'b1 && tx_prev !== 1'b1) bursts <= bursts + 1;
      if (in_wait_init === 1'b1 && tx_comreset !== 1'b0) noisy <= noisy + 1;
   end

   function automatic logic st_out(input int w);
      case (w)
         0: return in_reset;
         1: return in_wait_init;
         2: return in_wait_clear;
         default: return calib_go;
      endcase
   endfunction

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic wait_st(input int w, input int bound);
      int n;
      n = 0;
      while (st_out(w) !== 1'b1 && n < bound) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk($sformatf("reach state %0d", w), 1, st_out(w) === 1'b1);
   endtask

   task automatic t_power_on;
      wait_st(1, 300);
      chk("bursts after power-on", 6, bursts);
      wait_st(2, 200);
      while (cominit_pin !== 1'b0) @(posedge core_clk);
      #1;
      chk("held in wait clear", 1, in_wait_clear);
      wait_st(3, 20);
   endtask

   task automatic t_hold_req;
      int b0;
      b0 = bursts;
      @(posedge core_clk);
      resp_dly <= 8'h5A;
      reset_req <= 1'b1;
      @(posedge core_clk);
      #1;
      chk("reset on request", 1, in_reset);
      repeat (150) @(posedge core_clk);
      reset_req <= 1'b0;
      wait_st(1, 300);
      chk("whole groups", 1, (bursts - b0) % 6 == 0 && bursts - b0 >= 12);
      wait_st(3, 400);
   endtask

   task automatic t_async;
      @(posedge core_clk);
      async_rec_en <= 1'b0;
      tb_cin <= 1'b1;
      repeat (20) @(posedge core_clk);
      tb_cin <= 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      chk("cominit ignored", 1, calib_go);
      @(posedge core_clk);
      async_rec_en <= 1'b1;
      tb_cin <= 1'b1;
      wait_st(0, 10);
      repeat (10) @(posedge core_clk);
      tb_cin <= 1'b0;
      wait_st(1, 1000);
      wait_st(3, 400);
   endtask

   task automatic t_retry;
      int n;
      @(posedge core_clk);
      answer_en <= 1'b0;
      reset_req <= 1'b1;
      @(posedge core_clk);
      reset_req <= 1'b0;
      wait_st(1, 300);
      n = 0;
      while (in_wait_init === 1'b1 && n < 400) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("retry span", 1, n >= 199 && n <= 202);
      chk("back to reset", 1, in_reset);
      @(posedge core_clk);
      async_rec_en <= 1'b0;
      wait_st(1, 300);
      repeat (400) @(posedge core_clk);
      #1;
      chk("waits without recovery", 1, in_wait_init);
      chk("quiet while waiting", 0, noisy);
   endtask

   task automatic finish_test;
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      t_power_on;
      t_hold_req;
      t_async;
      t_retry;
      finish_test;
   end

   // Every scenario together takes well under 6000 cycles.
   initial begin
      #(20000 * 25);
      err_count++;
      finish_test;
   end
endmodule
